// ### src/io_port_regs.svh
`ifndef IO_PORT_REGS_SVH
`define IO_PORT_REGS_SVH
// register indices; byte address is four times the index
`define IDX_PORT_PIN_DATA 8'h05
`define IDX_PORT_DIRECTION 8'h85
`define IDX_PORT_CONFIG 8'h20
`define IDX_INTERRUPT_CONTROL 8'h21
// interrupt_control fields
`define BIT_CHANGE_FLAG 0
`define BIT_CHANGE_INTERRUPT_ENABLE 3
// port_config fields
`define CFG_OSC_LSB 0
`define CFG_OSC_MSB 2
`define CFG_MASTER_CLEAR_BIT 4
`define CFG_PULLUP_BIT 5
`define CFG_ANALOG_LSB 8
`define CFG_ANALOG_MSB 11
// reset values
`define DIRECTION_RESET 6'h3f
`define ANALOG_RESET 4'hf
`define OSC_RESET 3'h3
`endif

// ### src/io_port_pkg.sv
package io_port_pkg;
  // oscillator selection held in port_config
  typedef enum logic [2:0] {
    OSC_LP,
    OSC_XT,
    OSC_HS,
    OSC_INTERNAL_RC_MODE_IO,
    OSC_INTERNAL_RC_MODE_CLOCK_OUTPUT,
    OSC_EXTERNAL_RC_MODE_IO,
    OSC_EXTERNAL_RC_MODE_CLOCK_OUTPUT
  } osc_mode_t;
endpackage

// ### src/six_bit_io_port.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_port_regs.svh"
// Function
// - data register reads return pin levels, never the output latch
// - reset loads direction with all ones, every pin an input
// - data register is 8 bits; bits 6 and 7 are eeprom lines
// - direction 1 floats the pin, 0 drives it from its latch
// - pin 3 direction reads 1; direction bits 6 and 7 read 0
// - pins on alternate functions read 0 in the data register
// - pull-ups and change interrupt on pins 0, 1, 3 as one group
// - master clear on pin 3: pull-up forced, no change interrupt, reads 0
// - change interrupt works only while the enable bit is set
// - crystal modes take over pins 4 and 5; external rc modes take pin 5
// - direction bits 5:4 writable only in rc modes, else forced 1
// - clock output on pin 4 ignores its direction bit
// - latches hold until rewritten; inputs are sampled at read time
// - after power-on pins 0, 1, 2, 4 are analog and read 0
// - data writes load latches; read-modify-write works on pin levels
// - without eeprom the serial bits are unimplemented
module six_bit_io_port #(
  parameter bit has_eeprom = 1'b1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // package pins
  input wire logic [5:0] pad_in,
  output logic [5:0] pad_out,
  output logic [5:0] pad_oe,
  output logic [5:0] pad_pullup,
  // internal eeprom serial lines
  input wire logic eeprom_data_in,
  input wire logic eeprom_clock_in,
  output logic eeprom_data_bit,
  output logic eeprom_clock_bit,
  // oscillator clock output source and change event
  input wire logic clock_output_src,
  output logic change_event
);
  import io_port_pkg::*;

  logic [5:0] lat_r;
  logic [1:0] ee_lat_r;
  logic [5:0] dir_r;
  osc_mode_t osc_r;
  logic master_clear_input_r;
  logic pullup_r;
  logic [3:0] analog_r;
  logic cie_r;
  logic flag_r;
  logic flag_nxt;
  logic event_r;
  logic [2:0] prev_r;
  logic wr_r;
  logic [7:0] widx_r;
  logic [31:0] rdata_r;
  logic acc;
  logic [7:0] aidx;
  logic xtal;
  logic external_rc_mode;
  logic clock_output;
  logic dir45_wr;
  logic [5:0] alt;
  logic [5:0] dir_eff;
  logic [7:0] data_rd;
  logic [2:0] chg;
  logic flag_set;
  logic flag_clr;
  logic [31:0] rd_val;

  // byte address of a register index; upper address bits must be zero
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:10] == 22'h0) && (a[9:2] == idx);
  endfunction

  // address phase qualification on hsel, htrans[1] and hready; hsize is not checked
  assign acc = hsel && htrans[1] && hready;
  assign aidx = haddr[9:2];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // oscillator decode
  assign xtal = (osc_r == OSC_LP) || (osc_r == OSC_XT) || (osc_r == OSC_HS);
  assign external_rc_mode = (osc_r == OSC_EXTERNAL_RC_MODE_IO) || (osc_r == OSC_EXTERNAL_RC_MODE_CLOCK_OUTPUT);
  assign clock_output = (osc_r == OSC_INTERNAL_RC_MODE_CLOCK_OUTPUT) || (osc_r == OSC_EXTERNAL_RC_MODE_CLOCK_OUTPUT);
  assign dir45_wr = !xtal; // rc modes only

  // pins held by alternate functions
  assign alt[0] = analog_r[0];
  assign alt[1] = analog_r[1];
  assign alt[2] = analog_r[2];
  assign alt[3] = master_clear_input_r;
  assign alt[4] = analog_r[3] || xtal || clock_output;
  assign alt[5] = xtal || external_rc_mode;

  // effective direction: bit 3 fixed input, 5:4 forced outside rc modes
  assign dir_eff = {dir45_wr ? dir_r[5:4] : 2'b11, 1'b1, dir_r[2:0]};

  // read value samples live pins; nothing is latched on input
  assign data_rd[5:0] = pad_in & ~alt;
  assign data_rd[7:6] = has_eeprom ? {eeprom_clock_in, eeprom_data_in} : 2'b00;

  // pad drive; pin 4 carries the clock output regardless of direction
  always_comb begin
    pad_out = lat_r;
    pad_oe = ~dir_eff & ~alt;
    if (clock_output) begin
      pad_out[4] = clock_output_src;
      pad_oe[4] = 1'b1;
    end
    pad_oe[3] = 1'b0;
  end

  // one group enable; master clear forces its own pull-up
  assign pad_pullup = {2'b00, pullup_r || master_clear_input_r, 1'b0, pullup_r, pullup_r};

  // eeprom lines are always driven from their latches; direction reads 0
  assign eeprom_data_bit = ee_lat_r[0];
  assign eeprom_clock_bit = ee_lat_r[1];

  // read mux
  always_comb begin
    rd_val = 32'h0;
    if (hit(haddr, `IDX_PORT_PIN_DATA)) begin
      rd_val[7:0] = data_rd;
    end else if (hit(haddr, `IDX_PORT_DIRECTION)) begin
      rd_val[7:0] = {2'b00, dir_eff};
    end else if (hit(haddr, `IDX_PORT_CONFIG)) begin
      rd_val[`CFG_OSC_MSB:`CFG_OSC_LSB] = osc_r;
      rd_val[`CFG_MASTER_CLEAR_BIT] = master_clear_input_r;
      rd_val[`CFG_PULLUP_BIT] = pullup_r;
      rd_val[`CFG_ANALOG_MSB:`CFG_ANALOG_LSB] = analog_r;
    end else if (hit(haddr, `IDX_INTERRUPT_CONTROL)) begin
      rd_val[`BIT_CHANGE_INTERRUPT_ENABLE] = cie_r;
      rd_val[`BIT_CHANGE_FLAG] = flag_r;
    end
  end

  // read data is captured at the address phase so the pins are sampled then
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_r <= 32'h0;
    end else if (acc && !hwrite) begin
      rdata_r <= rd_val;
    end
  end

  // write address phase is held for the data phase
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_r <= 1'b0;
      widx_r <= 8'h0;
    end else begin
      wr_r <= acc && hwrite && (haddr[31:10] == 22'h0);
      widx_r <= aidx;
    end
  end

  // output latches; a write of read-back pin levels overwrites all six pin latches, the eeprom pair only with has_eeprom
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_r <= 6'h0;
      ee_lat_r <= 2'b11;
    end else if (wr_r && (widx_r == `IDX_PORT_PIN_DATA)) begin
      lat_r <= hwdata[5:0];
      if (has_eeprom) begin
        ee_lat_r <= hwdata[7:6];
      end
    end
  end

  // direction; bit 3 never leaves 1, bits 5:4 ignore writes in crystal modes
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_r <= `DIRECTION_RESET;
    end else if (wr_r && (widx_r == `IDX_PORT_DIRECTION)) begin
      dir_r[2:0] <= hwdata[2:0];
      if (dir45_wr) begin
        dir_r[5:4] <= hwdata[5:4];
      end
    end
  end

  // configuration: oscillator, master clear, pull-ups, analog pins
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_r <= osc_mode_t'(`OSC_RESET);
      master_clear_input_r <= 1'b0;
      pullup_r <= 1'b0;
      analog_r <= `ANALOG_RESET;
    end else if (wr_r && (widx_r == `IDX_PORT_CONFIG)) begin
      case (hwdata[`CFG_OSC_MSB:`CFG_OSC_LSB])
        3'h7: osc_r <= osc_r; // unused code keeps the current mode
        default: osc_r <= osc_mode_t'(hwdata[`CFG_OSC_MSB:`CFG_OSC_LSB]);
      endcase
      master_clear_input_r <= hwdata[`CFG_MASTER_CLEAR_BIT];
      pullup_r <= hwdata[`CFG_PULLUP_BIT];
      analog_r <= hwdata[`CFG_ANALOG_MSB:`CFG_ANALOG_LSB];
    end
  end

  // change detect on pins 3, 1, 0; analog or master clear pins drop out
  assign chg = ({pad_in[3], pad_in[1:0]} ^ prev_r) & {~master_clear_input_r, ~analog_r[1:0]};
  assign flag_set = cie_r && (chg != 3'h0);
  assign flag_clr = wr_r && (widx_r == `IDX_INTERRUPT_CONTROL) && !hwdata[`BIT_CHANGE_FLAG];
  assign flag_nxt = flag_set || (flag_r && !flag_clr); // set wins over clear

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 3'h0;
      flag_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      prev_r <= {pad_in[3], pad_in[1:0]};
      flag_r <= flag_nxt;
      event_r <= flag_set;
    end
  end
  assign change_event = event_r;

  // interrupt_control enable bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cie_r <= 1'b0;
    end else if (wr_r && (widx_r == `IDX_INTERRUPT_CONTROL)) begin
      cie_r <= hwdata[`BIT_CHANGE_INTERRUPT_ENABLE];
    end
  end

  // checks
  sequence data_write_s;
    acc && hwrite && hit(haddr, `IDX_PORT_PIN_DATA) ##1 1'b1;
  endsequence

  sequence data_read_s;
    acc && !hwrite && hit(haddr, `IDX_PORT_PIN_DATA);
  endsequence

  read_pins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_read_s |=> hrdata[5:0] == ($past(pad_in) & ~$past(alt)))
    else $error("pin read does not reflect pad levels");
  alt_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_read_s ##0 analog_r[0] |=> hrdata[0] == 1'b0)
    else $error("analog pin read nonzero");
  dir_reset_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(rst_n) |-> dir_eff == 6'h3f)
    else $error("direction not all ones after reset");
  dir_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc && !hwrite && hit(haddr, `IDX_PORT_DIRECTION) |=> hrdata[7:6] == 2'b00 && hrdata[3])
    else $error("fixed direction bits wrong");
  drive_dir_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !analog_r[0] |-> pad_oe[0] == !dir_r[0])
    else $error("pin 0 drive does not follow direction");
  latch_load_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_write_s |=> lat_r == $past(hwdata[5:0]))
    else $error("data write did not load latches");
  latch_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !(wr_r && widx_r == `IDX_PORT_PIN_DATA) |=> $stable(lat_r))
    else $error("latch changed without a write");
  pullup_group_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pad_pullup[0] == pad_pullup[1] && (master_clear_input_r || pad_pullup[3] == pad_pullup[0]))
    else $error("pull-up group split");
  master_clear_input_pull_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    master_clear_input_r && $changed(pad_in[3]) && !$changed(pad_in[1:0]) |=> !$rose(flag_r) && pad_pullup[3])
    else $error("master clear pin took part in change detect");
  change_gate_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $rose(flag_r) |-> $past(cie_r) && $past(chg != 3'h0))
    else $error("change flag set while disabled");
  osc_take_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    xtal |-> pad_oe[5:4] == 2'b00)
    else $error("crystal pins driven as port");
  dir_force_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !dir45_wr |-> dir_eff[5:4] == 2'b11)
    else $error("direction 5:4 not forced");
  clock_output_pin_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    clock_output |-> pad_oe[4] && pad_out[4] == clock_output_src)
    else $error("clock output not on pin 4");
  // a clear written in the cycle of a new change must not lose the event
  flag_wins_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    flag_set |=> flag_r)
    else $error("change flag lost to a clear");
  master_clear_input_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_read_s ##0 master_clear_input_r |=> hrdata[3] == 1'b0)
    else $error("master clear pin read nonzero");
  eeprom_off_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_read_s ##0 !has_eeprom |=> hrdata[7:6] == 2'b00)
    else $error("serial bits read without eeprom");
  unmapped_read_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    acc && !hwrite && (haddr[31:10] != 22'h0) |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule
`default_nettype wire

// ### verification/pin_board.sv
`timescale 1ns/1ps
`default_nettype none
// board around the package pins and the internal serial lines
module pin_board (
  // clock
  input wire logic core_clk,
  // design pin side
  input wire logic [5:0] pad_out,
  input wire logic [5:0] pad_oe,
  input wire logic [5:0] pad_pullup,
  output logic [5:0] pad_in,
  // outside drivers chosen by the bench
  input wire logic [5:0] ext_en,
  input wire logic [5:0] ext_val,
  // internal serial lines
  input wire logic eeprom_data_bit,
  input wire logic eeprom_clock_bit,
  output logic eeprom_data_in,
  output logic eeprom_clock_in
);
  logic flt = 1'b0;
  // an undriven pin without pull-up wanders, so no read may rely on it
  always @(posedge core_clk) begin
    flt <= ~flt;
  end
  // a strong outside driver beats the port buffer, like a shorted trace
  assign pad_in = (ext_en & ext_val) | (~ext_en & pad_oe & pad_out)
    | (~ext_en & ~pad_oe & (pad_pullup | {6{flt}}));
  // the serial lines only see the latch levels here
  assign eeprom_data_in = eeprom_data_bit;
  assign eeprom_clock_in = eeprom_clock_bit;
endmodule
`default_nettype wire

// ### verification/six_bit_io_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "io_port_regs.svh"
module six_bit_io_port_tb;
  import io_port_pkg::*;
  localparam logic [31:0] a_dat = {22'h0, `IDX_PORT_PIN_DATA, 2'b00};
  localparam logic [31:0] a_dir = {22'h0, `IDX_PORT_DIRECTION, 2'b00};
  localparam logic [31:0] a_cfg = {22'h0, `IDX_PORT_CONFIG, 2'b00};
  localparam logic [31:0] a_ict = {22'h0, `IDX_INTERRUPT_CONTROL, 2'b00};
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic clock_output_src = 1'b0;
  logic [5:0] ext_en = 6'h3f;
  logic [5:0] ext_val = 6'h00;
  logic hreadyout, hresp, change_event, ed_in, ec_in, ed_bit, ec_bit;
  logic [31:0] hrdata;
  logic [5:0] pad_in, pad_out, pad_oe, pad_pullup;
  logic [31:0] exp_q[$];
  logic [31:0] seed = 32'h3c3b;
  logic [31:0] v;
  logic [31:0] exp_v;
  logic [31:0] hrdata_nb;
  logic ed_nb, ec_nb;
  logic rd_ph = 1'b0;
  logic a4, a5;
  int mismatches = 0;
  int checks_done = 0;
  int ev_cnt = 0;
  int m;
  six_bit_io_port u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pad_in(pad_in),
    .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup), .eeprom_data_in(ed_in),
    .eeprom_clock_in(ec_in), .eeprom_data_bit(ed_bit), .eeprom_clock_bit(ec_bit),
    .clock_output_src(clock_output_src), .change_event(change_event));
  pin_board u_board (
    .core_clk(core_clk), .pad_out(pad_out), .pad_oe(pad_oe), .pad_pullup(pad_pullup),
    .pad_in(pad_in), .ext_en(ext_en), .ext_val(ext_val), .eeprom_data_bit(ed_bit),
    .eeprom_clock_bit(ec_bit), .eeprom_data_in(ed_in), .eeprom_clock_in(ec_in));
  // variant without eeprom; its serial inputs are tied high so a leak would show
  six_bit_io_port #(.has_eeprom(1'b0)) u_dut_bare (
    .core_clk(core_clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(), .hresp(), .hrdata(hrdata_nb), .pad_in(pad_in),
    .pad_out(), .pad_oe(), .pad_pullup(), .eeprom_data_in(1'b1),
    .eeprom_clock_in(1'b1), .eeprom_data_bit(ed_nb), .eeprom_clock_bit(ec_nb),
    .clock_output_src(clock_output_src), .change_event());
  // clock and a toggling clock-out source
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    clock_output_src <= ~clock_output_src;
  end
  // read data is taken at the edge that ends the data phase
  always @(posedge core_clk) begin
    if (rd_ph && hreadyout === 1'b1) begin
      checks_done++;
      exp_v = exp_q.pop_front();
      if (hrdata !== exp_v) begin
        mismatches++;
        $display("wrong value at %0t: read %h expected %h", $time, hrdata, exp_v);
      end
    end
    rd_ph <= htrans[1] && !hwrite && hreadyout;
    if (change_event === 1'b1) ev_cnt++;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic wrap_up();
    if (mismatches == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait for hready; a hang ends the run
  task automatic wait_rdy();
    int n;
    for (n = 0; n < 40; n++) begin
      @(posedge core_clk);
      if (hreadyout === 1'b1) break;
    end
    if (n == 40) begin
      mismatches++;
      $display("wrong value at %0t: bus never ready", $time);
      wrap_up();
    end
  endtask
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask
  // pin outputs are looked at mid-cycle, once the write has landed
  task automatic pins(input bit pull, input logic [5:0] exp);
    logic [5:0] got;
    @(negedge core_clk);
    got = pull ? pad_pullup : pad_oe;
    chk({26'h0, got}, {26'h0, exp});
    @(posedge core_clk);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    v = rnd();
    ext_val <= v[5:0];
    @(posedge core_clk);
    chk({26'h0, pad_oe}, 32'h0);
    rd(a_dir, 32'h3f);
    rd(a_dat, {24'h0, 2'b11, v[5], 1'b0, v[3], 3'h0});
    wr_seq();
  end
  task automatic wr_seq();
    bus(a_cfg, 1'b1, 32'h003);
    bus(a_dir, 1'b1, 32'hff);
    bus(a_dir, 1'b1, 32'h00);
    rd(a_dir, 32'h08);
    pins(1'b0, 6'h37);
    v = rnd();
    ext_en <= 6'h08;
    bus(a_dat, 1'b1, {24'h0, 2'b11, v[5:0]});
    rd(a_dat, {24'h0, 2'b11, v[5:4], ext_val[3], v[2:0]});
    ext_val <= ~ext_val;
    rd(a_dat, {24'h0, 2'b11, v[5:4], ~ext_val[3], v[2:0]});
    ext_en <= 6'h3f;
    v = rnd();
    ext_val <= v[5:0];
    rd(a_dat, {24'h0, 2'b11, v[5:0]});
    bus(a_dat, 1'b1, {24'h0, 2'b01, v[5:0] ^ 6'h21});
    ext_en <= 6'h08;
    rd(a_dat, {24'h0, 2'b01, v[5:0] ^ 6'h21});
    chk({30'h0, hrdata_nb[7:6]}, 32'h0);
    chk({30'h0, ec_nb, ed_nb}, 32'h3);
    bus(a_dat, 1'b1, 32'hff);
    ext_en <= 6'h3f;
    for (m = 0; m < 7; m++) begin
      bus(a_cfg, 1'b1, m);
      bus(a_dir, 1'b1, 32'h10);
      rd(a_dir, (m < 3) ? 32'h38 : 32'h18);
      a4 = (m < 3) || m == 4 || m == 6;
      a5 = (m < 3) || m == 5 || m == 6;
      v = rnd();
      ext_val <= v[5:0];
      rd(a_dat, {24'h0, 2'b11, v[5] & ~a5, v[4] & ~a4, v[3:0]});
      if (m == 4 || m == 6) begin
        @(negedge core_clk);
        chk({31'h0, pad_oe[4]}, 32'h1);
        @(posedge core_clk);
        bus(a_dir, 1'b1, 32'h00);
        @(negedge core_clk);
        chk({31'h0, pad_oe[4]}, 32'h1);
        @(posedge core_clk);
      end
    end
    bus(a_cfg, 1'b1, 32'h033);
    pins(1'b1, 6'h0b);
    rd(a_dat, {24'h0, 2'b11, ext_val[5:4], 1'b0, ext_val[2:0]});
    bus(a_cfg, 1'b1, 32'h013);
    pins(1'b1, 6'h08);
    ext_val <= ext_val ^ 6'h01;
    repeat (4) @(posedge core_clk);
    rd(a_ict, 32'h0);
    bus(a_ict, 1'b1, 32'h08);
    m = ev_cnt;
    ext_val <= ext_val ^ 6'h08;
    repeat (4) @(posedge core_clk);
    chk(ev_cnt, m);
    ext_val <= ext_val ^ 6'h01;
    repeat (4) @(posedge core_clk);
    chk(ev_cnt, m + 1);
    rd(a_ict, 32'h09);
    bus(a_ict, 1'b1, 32'h08);
    rd(a_ict, 32'h08);
    bus(32'h018, 1'b1, 32'hffff_ffff);
    rd(32'h018, 32'h0);
    rd(32'h400, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    repeat (3) @(posedge core_clk);
    wrap_up();
  endtask
endmodule
`default_nettype wire
